// file: hdl/clock_output_gate.sv
// divided clock output with glitch-free stop-low and full-period restart
`timescale 1ns/1ns
module clock_output_gate #(
    parameter int HALF = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic pll_on_i,
    input wire logic run_i,
    output logic clk_o,
    output logic stopped_o,
    output logic rise_o,
    output logic fall_o
);
    localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [CW-1:0] TERM = CW'(HALF - 1);

    logic [CW-1:0] cnt_ff;
    logic phase_ff;
    logic open_ff;
    logic out_ff;
    logic [CW-1:0] nxt_cnt;
    logic nxt_phase;
    logic nxt_open;
    logic nxt_out;
    logic toggle;

    // divider free-runs while the pll is on; gate only moves on a toggle or when the pll is off
    always_comb
    begin
        toggle = pll_on_i && (cnt_ff == TERM);
        nxt_cnt = (!pll_on_i || toggle) ? '0 : cnt_ff + CW'(1);
        nxt_phase = !pll_on_i ? 1'b0 : (toggle ? ~phase_ff : phase_ff);
        nxt_open = open_ff;
        if (!pll_on_i)
        begin
            nxt_open = 1'b0;
        end
        else if (toggle)
        begin
            // close on a falling transition so the last high is never cut short
            if (open_ff && !run_i && phase_ff)
            begin
                nxt_open = 1'b0;
            end
            // reopen only where a full period begins
            else if (!open_ff && run_i && !phase_ff)
            begin
                nxt_open = 1'b1;
            end
        end
        nxt_out = nxt_open & nxt_phase;
        rise_o = toggle && !phase_ff && nxt_open;
        fall_o = toggle && phase_ff && open_ff;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff <= '0;
            phase_ff <= 1'b0;
            open_ff <= 1'b0;
            out_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            phase_ff <= nxt_phase;
            open_ff <= nxt_open;
            out_ff <= nxt_out;
        end
    end

    assign clk_o = out_ff;
    assign stopped_o = ~open_ff;
endmodule : clock_output_gate

// file: hdl/clock_powerdown_pkg.sv
// shared constants, state encoding and control carrier for the power-down sequencer
package clock_powerdown_pkg;

    // reference clock rate driving all sequencing logic
    localparam int CLK_MHZ = 25;

    // longest allowed time from supply/wake to stable outputs, in microseconds
    localparam int STABLE_MAX_US = 3000;
    // longest time converted exactly to whole cycles
    localparam int STABLE_MAX_CYC = (STABLE_MAX_US * CLK_MHZ);
    // relock wait: half the stable budget leaves room for the output restart period
    localparam int LOCK_DEFAULT_CYC = STABLE_MAX_CYC / 2;
    localparam int LOCK_CNT_W = 17;

    // consecutive low samples of the request needed before power-down starts
    localparam logic [1:0] PD_LOW_SAMPLES = 2'h2;

    // host family select encoding
    localparam logic HOST_SEL_DIFF = 1'b1;
    localparam logic HOST_SEL_OPEN_DRAIN = 1'b0;

    // divider half periods, in reference cycles, and default non-host output count
    localparam int HOST_HALF_DEFAULT = 2;
    localparam int PERIPH_HALF_BASE = 3;
    localparam int NUM_PERIPH_DEFAULT = 4;

    // sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_WAIT_PG = 7'h01,
        ST_LOCK = 7'h02,
        ST_RUN = 7'h04,
        ST_STOP = 7'h08,
        ST_PARK = 7'h10,
        ST_OFF = 7'h20,
        ST_WAKE = 7'h40
    } seq_state_t;

    // control bundle driven by the sequencer
    typedef struct packed {
        logic osc_on;
        logic pll_on;
        logic smbus_en;
        logic outputs_run;
        logic host_park;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{
        osc_on: 1'b1,
        pll_on: 1'b0,
        smbus_en: 1'b0,
        outputs_run: 1'b0,
        host_park: 1'b0
    };

endpackage : clock_powerdown_pkg

// file: hdl/clock_powerdown_sequencer.sv
// power-down entry and exit sequencer for a multi-output clock generator
//
// Functional notes
// - A select level of one chooses differential-host behaviour and zero open-drain behaviour.
// - Differential mode gates non-host outputs low at their next fall after two low samples.
// - Differential power-down parks the true host pin high at double current, complement off.
// - Differential mode may need several output cycles before all outputs are held low.
// - Differential mode resumes running outputs well within three milliseconds of release.
// - Open-drain mode stops all outputs low synchronously after two low host-rise samples; the gates stop each output at its own next fall.
// - Open-drain shutdown turns off the plls and the crystal oscillator once outputs stop.
// - Open-drain shutdown disables the serial management port until the device wakes.
// - Open-drain release restarts each output on the rise that opens a full period.
// - The power-good qualifier matters only at power-up and is ignored after it goes low.
// - After power-up all outputs become stable within three milliseconds.
`timescale 1ns/1ns
module clock_powerdown_sequencer
    import clock_powerdown_pkg::*;
#(
    parameter int NUM_PERIPH = NUM_PERIPH_DEFAULT,
    parameter int HOST_HALF = HOST_HALF_DEFAULT,
    parameter int LOCK_CYC = LOCK_DEFAULT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic power_down_req_n_i,
    input wire logic host_family_select_i,
    input wire logic vtt_power_good_n_i,
    output logic host_clock_pair_t_o,
    output logic host_clock_pair_t_oe_o,
    output logic host_clock_pair_c_o,
    output logic host_clock_pair_c_oe_o,
    output logic iref_double_o,
    output logic [NUM_PERIPH-1:0] periph_clk_o,
    output logic osc_enable_o,
    output logic pll_enable_o,
    output logic smbus_enable_o,
    output logic powered_down_o
);
    localparam logic [LOCK_CNT_W-1:0] LOCK_TERM = LOCK_CNT_W'(LOCK_CYC - 1);

    // synchronised pin levels
    logic pd_req_n_s;
    logic host_sel_s;
    logic pg_n_s;

    // sequencer state
    seq_state_t state_ff;
    seq_state_t nxt_state;
    ctrl_t ctrl_ff;
    ctrl_t nxt_ctrl;
    logic mode_diff_ff;
    logic nxt_mode_diff;
    logic [LOCK_CNT_W-1:0] lock_cnt_ff;
    logic [LOCK_CNT_W-1:0] nxt_lock_cnt;
    logic [1:0] pd_low_cnt_ff;
    logic [1:0] nxt_pd_low_cnt;
    logic pg_seen_ff;
    logic nxt_pg_seen;

    // registered pin drivers
    logic host_t_ff;
    logic host_t_oe_ff;
    logic host_c_ff;
    logic host_c_oe_ff;
    logic iref2_ff;
    logic nxt_host_t;
    logic nxt_host_t_oe;
    logic nxt_host_c;
    logic nxt_host_c_oe;
    logic nxt_iref2;

    // clock generator observation
    logic host_clk;
    logic host_stopped;
    logic host_rise;
    logic host_fall;
    logic [NUM_PERIPH-1:0] periph_stopped;
    logic all_stopped;
    logic sample_edge;
    logic pd_confirmed;

    two_flop_sync #(
        .WIDTH(3),
        .RESET_VAL(3'h7)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i({power_down_req_n_i, host_family_select_i, vtt_power_good_n_i}),
        .sync_o({pd_req_n_s, host_sel_s, pg_n_s})
    );

    // host clock source; true rise and fall strobes drive request sampling
    clock_output_gate #(
        .HALF(HOST_HALF)
    ) u_host_gate (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pll_on_i(ctrl_ff.pll_on),
        .run_i(ctrl_ff.outputs_run),
        .clk_o(host_clk),
        .stopped_o(host_stopped),
        .rise_o(host_rise),
        .fall_o(host_fall)
    );

    // one gated divider per non-host output, each at its own rate
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PERIPH; gi++)
        begin : g_periph
            // stop each output at its next fall
            clock_output_gate #(
                .HALF(PERIPH_HALF_BASE + gi)
            ) u_periph_gate (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .pll_on_i(ctrl_ff.pll_on),
                .run_i(ctrl_ff.outputs_run),
                .clk_o(periph_clk_o[gi]),
                .stopped_o(periph_stopped[gi]),
                .rise_o(),
                .fall_o()
            );
        end
    endgenerate

    assign all_stopped = host_stopped & (&periph_stopped);

    // sampling edge follows the live select: complement rise is the true fall
    always_comb
    begin
        if (host_sel_s == HOST_SEL_DIFF)
        begin
            sample_edge = host_fall;
        end
        else
        begin
            sample_edge = host_rise;
        end
    end

    // count consecutive low samples; any high sample starts over
    always_comb
    begin
        nxt_pd_low_cnt = pd_low_cnt_ff;
        if (state_ff != ST_RUN)
        begin
            nxt_pd_low_cnt = 2'h0;
        end
        else if (sample_edge)
        begin
            if (pd_req_n_s)
            begin
                nxt_pd_low_cnt = 2'h0;
            end
            else if (pd_low_cnt_ff != PD_LOW_SAMPLES)
            begin
                nxt_pd_low_cnt = pd_low_cnt_ff + 2'h1;
            end
        end
        pd_confirmed = (pd_low_cnt_ff == PD_LOW_SAMPLES);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pd_low_cnt_ff <= 2'h0;
        end
        else
        begin
            pd_low_cnt_ff <= nxt_pd_low_cnt;
        end
    end

    // power-good is latched once; later toggles cannot pull the part back
    always_comb
    begin
        nxt_pg_seen = pg_seen_ff | ~pg_n_s;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pg_seen_ff <= 1'b0;
        end
        else
        begin
            pg_seen_ff <= nxt_pg_seen;
        end
    end

    // main sequencer: power-up lock, run, stop, park or shutdown, wake
    always_comb
    begin
        nxt_state = state_ff;
        nxt_ctrl = ctrl_ff;
        nxt_mode_diff = mode_diff_ff;
        nxt_lock_cnt = lock_cnt_ff;
        case (state_ff)
            ST_WAIT_PG:
            begin
                if (pg_seen_ff)
                begin
                    nxt_state = ST_LOCK;
                    nxt_ctrl.pll_on = 1'b1;
                    nxt_lock_cnt = '0;
                end
            end
            ST_LOCK, ST_WAKE:
            begin
                if (lock_cnt_ff == LOCK_TERM)
                begin
                    nxt_state = ST_RUN;
                    nxt_ctrl.outputs_run = 1'b1;
                    nxt_ctrl.smbus_en = 1'b1;
                end
                else
                begin
                    nxt_lock_cnt = lock_cnt_ff + LOCK_CNT_W'(1);
                end
            end
            ST_RUN:
            begin
                if (pd_confirmed)
                begin
                    // mode is frozen here so a select change mid-sequence is harmless
                    nxt_state = ST_STOP;
                    nxt_ctrl.outputs_run = 1'b0;
                    nxt_mode_diff = (host_sel_s == HOST_SEL_DIFF);
                end
            end
            ST_STOP:
            begin
                // wait for every output to settle low
                if (all_stopped)
                begin
                    if (mode_diff_ff)
                    begin
                        nxt_state = ST_PARK;
                        nxt_ctrl.host_park = 1'b1;
                    end
                    else
                    begin
                        nxt_state = ST_OFF;
                        nxt_ctrl.pll_on = 1'b0;
                        nxt_ctrl.osc_on = 1'b0;
                        nxt_ctrl.smbus_en = 1'b0;
                    end
                end
            end
            ST_PARK:
            begin
                // pll kept running, so release is immediate
                if (pd_req_n_s)
                begin
                    nxt_state = ST_RUN;
                    nxt_ctrl.host_park = 1'b0;
                    nxt_ctrl.outputs_run = 1'b1;
                end
            end
            ST_OFF:
            begin
                if (pd_req_n_s)
                begin
                    // relock first; gates reopen on a full period
                    nxt_state = ST_WAKE;
                    nxt_ctrl.osc_on = 1'b1;
                    nxt_ctrl.pll_on = 1'b1;
                    nxt_lock_cnt = '0;
                end
            end
            default:
            begin
                nxt_state = ST_WAIT_PG;
                nxt_ctrl = CTRL_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= ST_WAIT_PG;
            ctrl_ff <= CTRL_RESET;
            mode_diff_ff <= HOST_SEL_DIFF;
            lock_cnt_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            ctrl_ff <= nxt_ctrl;
            mode_diff_ff <= nxt_mode_diff;
            lock_cnt_ff <= nxt_lock_cnt;
        end
    end

    // host pin drive; one cycle of lag keeps every pin straight from a flop
    always_comb
    begin
        nxt_host_t = host_clk;
        nxt_host_t_oe = 1'b1;
        nxt_host_c = ~host_clk;
        nxt_host_c_oe = 1'b1;
        nxt_iref2 = 1'b0;
        if (ctrl_ff.host_park)
        begin
            nxt_host_t = 1'b1;
            nxt_iref2 = 1'b1;
            nxt_host_c = 1'b0;
            nxt_host_c_oe = 1'b0;
        end
        else if (host_stopped)
        begin
            // both legs held low while stopped
            nxt_host_t = 1'b0;
            nxt_host_c = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            host_t_ff <= 1'b0;
            host_t_oe_ff <= 1'b1;
            host_c_ff <= 1'b0;
            host_c_oe_ff <= 1'b1;
            iref2_ff <= 1'b0;
        end
        else
        begin
            host_t_ff <= nxt_host_t;
            host_t_oe_ff <= nxt_host_t_oe;
            host_c_ff <= nxt_host_c;
            host_c_oe_ff <= nxt_host_c_oe;
            iref2_ff <= nxt_iref2;
        end
    end

    // outputs
    assign host_clock_pair_t_o = host_t_ff;
    assign host_clock_pair_t_oe_o = host_t_oe_ff;
    assign host_clock_pair_c_o = host_c_ff;
    assign host_clock_pair_c_oe_o = host_c_oe_ff;
    assign iref_double_o = iref2_ff;
    assign osc_enable_o = ctrl_ff.osc_on;
    assign pll_enable_o = ctrl_ff.pll_on;
    assign smbus_enable_o = ctrl_ff.smbus_en;
    assign powered_down_o = (state_ff == ST_PARK) || (state_ff == ST_OFF);

endmodule : clock_powerdown_sequencer

// file: hdl/two_flop_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module two_flop_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // first stage feeds only the second stage
    always_comb
    begin
        nxt_meta = async_i;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_ff <= RESET_VAL;
            sync_ff <= RESET_VAL;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_o = sync_ff;
endmodule : two_flop_sync

// file: tb/clock_powerdown_assertions.sv
// concurrent checks on the pins of the power-down sequencer
`timescale 1ns/1ns
module clock_powerdown_checker #(
    parameter int NUM_PERIPH = 4,
    parameter int LOCK_CYC = 20
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic power_down_req_n_i,
    input wire logic host_clock_pair_t_o,
    input wire logic host_clock_pair_t_oe_o,
    input wire logic host_clock_pair_c_oe_o,
    input wire logic iref_double_o,
    input wire logic [NUM_PERIPH-1:0] periph_clk_o,
    input wire logic osc_enable_o,
    input wire logic pll_enable_o,
    input wire logic smbus_enable_o,
    input wire logic powered_down_o
);
    // wake budget: relock plus a few output periods
    localparam int WAKE_MAX = LOCK_CYC + 20;
    logic [2:0] low_run_ff;
    logic armed_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // a request must stay low across two host sampling points, five cycles, before it can count
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            low_run_ff <= 3'h0;
            armed_ff <= 1'b0;
        end
        else
        begin
            low_run_ff <= power_down_req_n_i ? 3'h0 : low_run_ff + {2'h0, low_run_ff != 3'h7};
            armed_ff <= !powered_down_o && (armed_ff || low_run_ff >= 3'h5);
        end
    end

    property p_glitch_reject; $rose(powered_down_o) |-> armed_ff; endproperty
    a_glitch_reject: assert property (p_glitch_reject)
        else $error("power-down entered on a short request");
    property p_pd_low; powered_down_o |-> periph_clk_o == '0; endproperty
    a_pd_low: assert property (p_pd_low)
        else $error("output running while powered down");
    property p_park_pins; !host_clock_pair_c_oe_o |-> host_clock_pair_t_o && iref_double_o
        && host_clock_pair_t_oe_o; endproperty
    a_park_pins: assert property (p_park_pins)
        else $error("host pair not parked high at double current");
    property p_park_pll; $rose(iref_double_o) |-> pll_enable_o && powered_down_o; endproperty
    a_park_pll: assert property (p_park_pll)
        else $error("park state without running pll");
    property p_off_enables; powered_down_o && !pll_enable_o |-> !osc_enable_o
        && !smbus_enable_o; endproperty
    a_off_enables: assert property (p_off_enables)
        else $error("oscillator or port left on in shutdown");
    property p_smbus_pll; smbus_enable_o |-> pll_enable_o && osc_enable_o; endproperty
    a_smbus_pll: assert property (p_smbus_pll)
        else $error("serial port on without clocks");
    property p_full_pulse; $rose(periph_clk_o[0]) |-> periph_clk_o[0] [*3]; endproperty
    a_full_pulse: assert property (p_full_pulse)
        else $error("partial high pulse on output");
    property p_diff_resume; $fell(powered_down_o) && smbus_enable_o |-> ##[1:16]
        periph_clk_o[0]; endproperty
    a_diff_resume: assert property (p_diff_resume)
        else $error("outputs slow to resume after park");
    property p_wake_time; $rose(osc_enable_o) |-> ##[1:WAKE_MAX] smbus_enable_o; endproperty
    a_wake_time: assert property (p_wake_time)
        else $error("wake from shutdown too slow");
    property p_outputs_start; $rose(smbus_enable_o) |-> ##[0:16] periph_clk_o[0]; endproperty
    a_outputs_start: assert property (p_outputs_start)
        else $error("outputs not started after lock");
endmodule : clock_powerdown_checker

bind clock_powerdown_sequencer clock_powerdown_checker #(.NUM_PERIPH(NUM_PERIPH),
    .LOCK_CYC(LOCK_CYC)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .power_down_req_n_i(power_down_req_n_i), .host_clock_pair_t_o(host_clock_pair_t_o),
    .host_clock_pair_t_oe_o(host_clock_pair_t_oe_o),
    .host_clock_pair_c_oe_o(host_clock_pair_c_oe_o), .iref_double_o(iref_double_o),
    .periph_clk_o(periph_clk_o), .osc_enable_o(osc_enable_o), .pll_enable_o(pll_enable_o),
    .smbus_enable_o(smbus_enable_o), .powered_down_o(powered_down_o));

// file: tb/power_manager_model.sv
// model of the power management logic that drives request and power-good
`timescale 1ns/1ns
module power_manager_model (
    input wire logic clk_i,
    output logic power_down_req_n_o,
    output logic vtt_power_good_n_o
);
    // both lines idle inactive until told otherwise
    initial
    begin
        power_down_req_n_o = 1'b1;
        vtt_power_good_n_o = 1'b1;
    end

    // change the request just after an edge, then hold it a number of cycles
    task automatic drive_req(input logic lvl, input int hold);
        @(posedge clk_i);
        power_down_req_n_o <= lvl;
        repeat (hold) @(posedge clk_i);
    endtask : drive_req

    task automatic drive_pg(input logic lvl);
        @(posedge clk_i);
        vtt_power_good_n_o <= lvl;
    endtask : drive_pg
endmodule : power_manager_model

// file: tb/tb_top.sv
// self-checking bench for the power-down sequencer
`timescale 1ns/1ns
module tb_top;
    import clock_powerdown_pkg::*;
    // short relock keeps the run brief
    localparam int LOCK = 20;
    logic clk_i, rst_n_i, sel, req_n, pg_n, t_o, t_oe, c_o, c_oe, iref2;
    logic osc_en, pll_en, smbus_en, pdown;
    logic [3:0] periph;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;

    power_manager_model u_pm (.clk_i(clk_i), .power_down_req_n_o(req_n),
        .vtt_power_good_n_o(pg_n));
    clock_powerdown_sequencer #(.NUM_PERIPH(4), .HOST_HALF(2), .LOCK_CYC(LOCK)) u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .power_down_req_n_i(req_n),
        .host_family_select_i(sel), .vtt_power_good_n_i(pg_n), .host_clock_pair_t_o(t_o),
        .host_clock_pair_t_oe_o(t_oe), .host_clock_pair_c_o(c_o),
        .host_clock_pair_c_oe_o(c_oe), .iref_double_o(iref2), .periph_clk_o(periph),
        .osc_enable_o(osc_en), .pll_enable_o(pll_en), .smbus_enable_o(smbus_en),
        .powered_down_o(pdown));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_total++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    // outputs are sampled on the falling edge, clear of the launching edge
    task automatic wait_down(input logic lvl, input int lim);
        int n;
        n = 0;
        while (pdown !== lvl && n < lim)
        begin
            @(negedge clk_i);
            n++;
        end
        check(pdown, lvl, "power-down state not reached");
    endtask : wait_down

    task automatic wait_smbus(output int n);
        n = 0;
        while (smbus_en !== 1'b1 && n < 200)
        begin
            @(negedge clk_i);
            n++;
        end
    endtask : wait_smbus

    // length of the next whole high phase of the first output
    task automatic high_len(output int len);
        int n;
        n = 0;
        len = 0;
        while (periph[0] !== 1'b0 && n < 20)
        begin
            @(negedge clk_i);
            n++;
        end
        while (periph[0] !== 1'b1 && n < 40)
        begin
            @(negedge clk_i);
            n++;
        end
        while (periph[0] === 1'b1 && len < 20)
        begin
            @(negedge clk_i);
            len++;
        end
    endtask : high_len

    task automatic set_sel(input logic v);
        @(posedge clk_i);
        sel <= v;
        repeat (8) @(posedge clk_i);
    endtask : set_sel

    task automatic t_power_up();
        int n;
        repeat (30) @(negedge clk_i);
        check(pll_en, 1'b0, "pll started before power-good");
        check(smbus_en, 1'b0, "port enabled before power-good");
        u_pm.drive_pg(1'b0);
        wait_smbus(n);
        check(n <= LOCK + 10, 1'b1, "outputs slow to become stable");
        high_len(n);
        check(n, PERIPH_HALF_BASE, "first pulse after power-up");
        u_pm.drive_pg(1'b1);
        repeat (40) @(negedge clk_i);
        check({smbus_en, pll_en, pdown}, 3'h6, "late power-good change acted on");
        $display("test power_up done");
    endtask : t_power_up

    task automatic t_glitch();
        set_sel(HOST_SEL_OPEN_DRAIN);
        // a low lasting one host period can hold at most one sample
        u_pm.drive_req(1'b0, 3);
        u_pm.drive_req(1'b1, 30);
        @(negedge clk_i);
        check({pdown, smbus_en}, 2'h1, "short request started power-down");
        $display("test glitch done");
    endtask : t_glitch

    task automatic t_diff_down();
        int n;
        set_sel(HOST_SEL_DIFF);
        u_pm.drive_req(1'b0, 0);
        wait_down(1'b1, 60);
        repeat (2) @(negedge clk_i);
        check(periph, 4'h0, "outputs not held low");
        check({t_o, t_oe, c_oe, iref2, c_o}, 5'h1A, "host pair not parked");
        check({pll_en, osc_en, smbus_en}, 3'h7, "differential park shut clocks");
        repeat (12) @(negedge clk_i);
        check(periph, 4'h0, "outputs woke while parked");
        u_pm.drive_req(1'b1, 0);
        wait_down(1'b0, 20);
        high_len(n);
        check(n, PERIPH_HALF_BASE, "resume pulse after park");
        $display("test diff_down done");
    endtask : t_diff_down

    task automatic t_od_down();
        int n;
        set_sel(HOST_SEL_OPEN_DRAIN);
        u_pm.drive_req(1'b0, 0);
        wait_down(1'b1, 60);
        @(negedge clk_i);
        check({periph, c_oe, t_o, c_o}, 7'h04, "outputs not stopped low");
        check({pll_en, osc_en}, 2'h0, "plls or oscillator left on");
        check(smbus_en, 1'b0, "serial port left on in shutdown");
        u_pm.drive_req(1'b1, 0);
        wait_smbus(n);
        check(n <= LOCK + 10, 1'b1, "wake from shutdown too slow");
        high_len(n);
        check(n, PERIPH_HALF_BASE, "partial pulse on restart");
        check({pdown, osc_en}, 2'h1, "not running after wake");
        $display("test od_down done");
    endtask : t_od_down

    initial
    begin
        rst_n_i = 1'b0;
        sel = HOST_SEL_DIFF;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_power_up();
        t_glitch();
        t_diff_down();
        t_od_down();
        conclude();
    end
endmodule : tb_top
